// File: rtl/xpt_ctl_pkg.sv
// Constants and types shared by the crosspoint programming controller.
// Functional notes
// - Preprogram: select low, write low, others high
// - Readback: select low, readback low, others high
// - Global update: select low, update low only
// - Transparent write: select, write, update all low
// - Controller never sends reserved address or input
package xpt_ctl_pkg;
	// Widths of the device buses
	localparam int ADDR_W = 5;
	localparam int SEL_W  = 6;
	localparam int DATA_W = 7;
	// Output enable position in the data word
	localparam int OE_BIT = 6;
	// Highest legal output and input numbers, and the broadcast address
	localparam logic [4:0] OUT_MAX   = 5'h10;
	localparam logic [4:0] BCAST_ADR = 5'h11;
	localparam logic [5:0] IN_MAX    = 6'h20;
	// Timing: strobe width, data setup and readback settle, in ns
	localparam int T_STROBE_NS = 15;
	localparam int T_SETUP_NS  = 15;
	localparam int T_READ_NS   = 40;
	localparam int CLK_NS      = 50;
	// Least times round up to whole cycles, never below one
	localparam int STROBE_CYC = ((T_STROBE_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam int SETUP_CYC  = ((T_SETUP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam int READ_CYC   = ((T_READ_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((T_READ_NS + CLK_NS - 1) / CLK_NS);
	localparam int CNT_W      = 4;
	// Software register word addresses
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_RDATA  = 4'h2;
	localparam logic [3:0] REG_RESET  = 4'h3;
	// Command register fields
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_OP_LSB   = 16;
	localparam int OP_W         = 2;
	// Status bits
	localparam int ST_BUSY  = 0;
	localparam int ST_ERR   = 1;
	localparam int ST_RESET = 2;
	// Reset value of the data read port
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	// Operation codes written by software
	typedef enum logic [1:0] {
		OP_PREPROG = 2'h0,
		OP_READ    = 2'h1,
		OP_UPDATE  = 2'h2,
		OP_TRANSP  = 2'h3
	} op_t;
	// Strobe pattern of one command: write, readback, update (all active low)
	typedef struct packed {
		logic we_n;
		logic re_n;
		logic upd_n;
	} strobe_t;
	// Decode an operation into its active strobe pattern
	function automatic strobe_t op_strobes(input op_t op);
		strobe_t s;
		s = '{we_n: 1'b1, re_n: 1'b1, upd_n: 1'b1};
		case (op)
			OP_PREPROG: s.we_n  = 1'b0;
			OP_READ:    s.re_n  = 1'b0;
			OP_UPDATE:  s.upd_n = 1'b0;
			OP_TRANSP: begin
				s.we_n  = 1'b0;
				s.upd_n = 1'b0;
			end
			default:    s = '{we_n: 1'b1, re_n: 1'b1, upd_n: 1'b1};
		endcase
		return s;
	endfunction
endpackage

// File: rtl/xpt_cmd_check.sv
// Legality check of one command before it reaches the pins.
`timescale 1ns/10ps
module xpt_cmd_check
	import xpt_ctl_pkg::*;
(
	input  wire logic [1:0]        i_op,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [SEL_W-1:0]  i_sel,
	output logic                   o_bad
);
	// Reserved codes are refused; broadcast readback is refused too
	always_comb begin
		o_bad = 1'b0;
		if (i_addr > BCAST_ADR) begin
			o_bad = 1'b1;
		end
		// input numbers 0 to 32
		// Input select only matters for commands that carry data
		if ((i_op != OP_UPDATE) && (i_op != OP_READ) && (i_sel > IN_MAX)) begin
			o_bad = 1'b1;
		end
		if ((i_op == OP_READ) && (i_addr == BCAST_ADR)) begin
			o_bad = 1'b1;
		end
	end
endmodule

// File: rtl/xpt_ctl.sv
// Host controller that programs the crosspoint through its parallel pins.
`timescale 1ns/10ps
module xpt_ctl
	import xpt_ctl_pkg::*;
(
	input  wire logic               i_mclk,
	input  wire logic               i_rst_n,
	// Software register port
	input  wire logic [3:0]         i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	output logic      [31:0]        o_rdata,
	// Device control pins
	output logic                    o_reset_n,
	output logic                    o_cs_n,
	output logic                    o_write_n,
	output logic                    o_readback_enable_n,
	output logic                    o_update_n,
	output logic      [ADDR_W-1:0]  o_out_sel,
	// Device data bus, three signals
	input  wire logic [DATA_W-1:0]  i_data,
	output logic      [DATA_W-1:0]  o_data,
	output logic                    o_data_oe
);
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_PULSE,
		ST_HOLD,
		ST_RDWAIT
	} state_t;

	state_t              state_reg;        // Current sequencer state
	logic [CNT_W-1:0]    cnt_reg;          // Phase cycle counter
	op_t                 op_reg;           // Operation in flight
	logic [6:0]          rdata_reg;        // Last readback word
	logic                err_reg;          // Sticky refused-command flag
	logic                bad;              // Command legality result
	logic                cmd_wr;           // Software writes a command
	op_t                 cmd_op;           // Operation field of write
	strobe_t             stb;              // Strobes for op in flight

	assign cmd_wr = i_wr && (i_addr == REG_CMD) && (state_reg == ST_IDLE);
	assign cmd_op = op_t'(i_wdata[CMD_OP_LSB +: OP_W]);
	assign stb    = op_strobes(op_reg);

	// Legality check of a new command
	xpt_cmd_check u_check (
		.i_op   (cmd_op),
		.i_addr (i_wdata[CMD_ADDR_LSB +: ADDR_W]),
		.i_sel  (i_wdata[CMD_DATA_LSB +: SEL_W]),
		.o_bad  (bad)
	);

	// Device reset pin, held low from our reset until software releases it
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_reset_n <= 1'b0;
		end else if (i_wr && (i_addr == REG_RESET)) begin
			o_reset_n <= i_wdata[0];
		end
	end

	// Sequencer: setup, strobe low, strobe high with data held, idle
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// Refused commands never leave idle
					if (cmd_wr && !bad) begin
						state_reg <= ST_SETUP;
						cnt_reg   <= CNT_W'(SETUP_CYC - 1);
					end
				end
				ST_SETUP: begin
					if (cnt_reg == '0) begin
						state_reg <= ST_PULSE;
						cnt_reg   <= CNT_W'((op_reg == OP_READ) ? READ_CYC - 1 : STROBE_CYC - 1);
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				ST_PULSE: begin
					if (cnt_reg == '0) begin
						state_reg <= (op_reg == OP_READ) ? ST_RDWAIT : ST_HOLD;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				ST_RDWAIT: state_reg <= ST_HOLD;
				ST_HOLD:   state_reg <= ST_IDLE;
				default:   state_reg <= ST_IDLE;
			endcase
		end
	end

	// Latch the command fields at acceptance
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			op_reg    <= OP_PREPROG;
			o_out_sel <= '0;
			o_data    <= '0;
		end else if (cmd_wr && !bad) begin
			op_reg <= cmd_op;
			o_out_sel <= i_wdata[CMD_ADDR_LSB +: ADDR_W];
			o_data <= i_wdata[CMD_DATA_LSB +: DATA_W];
		end
	end

	// Pins: chip select spans setup to hold, write and update strobes only in pulse, readback strobe through pulse and rdwait
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_cs_n              <= 1'b1;
			o_write_n           <= 1'b1;
			o_readback_enable_n <= 1'b1;
			o_update_n          <= 1'b1;
			o_data_oe           <= 1'b0;
		end else begin
			o_cs_n <= !((state_reg == ST_IDLE && cmd_wr && !bad) ||
			            (state_reg == ST_SETUP) || (state_reg == ST_PULSE) ||
			            (state_reg == ST_RDWAIT));
			o_write_n  <= !((state_reg == ST_SETUP && cnt_reg == '0) ||
			               (state_reg == ST_PULSE && cnt_reg != '0)) || stb.we_n;
			o_update_n <= !((state_reg == ST_SETUP && cnt_reg == '0) ||
			               (state_reg == ST_PULSE && cnt_reg != '0)) || stb.upd_n;
			o_readback_enable_n <= !((state_reg == ST_SETUP && cnt_reg == '0) ||
			                        (state_reg == ST_PULSE)) || stb.re_n;
			o_data_oe <= ((state_reg == ST_IDLE && cmd_wr && !bad && cmd_op != OP_READ && cmd_op != OP_UPDATE) ||
			              (state_reg != ST_IDLE && state_reg != ST_HOLD && op_reg != OP_READ
			               && op_reg != OP_UPDATE));
		end
	end

	// Readback capture while the device drives the bus
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rdata_reg <= '0;
		end else if (state_reg == ST_RDWAIT) begin
			rdata_reg <= i_data;
		end
	end

	// Sticky refusal flag; a new refusal wins over the clear
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			err_reg <= 1'b0;
		end else if (i_wr && (i_addr == REG_CMD) && (bad || state_reg != ST_IDLE)) begin
			err_reg <= 1'b1;
		end else if (i_wr && (i_addr == REG_STATUS) && i_wdata[ST_ERR]) begin
			err_reg <= 1'b0;
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_rdata <= ZERO_WORD;
		end else if (i_rd) begin
			case (i_addr)
				REG_STATUS: o_rdata <= {29'h0000_0000, !o_reset_n, err_reg, state_reg != ST_IDLE};
				REG_RDATA:  o_rdata <= {25'h000_0000, rdata_reg};
				REG_RESET:  o_rdata <= {31'h0000_0000, o_reset_n};
				REG_CMD:    o_rdata <= {14'h0000, 2'(op_reg), 3'h0, o_out_sel, 1'b0, o_data};
				default:    o_rdata <= ZERO_WORD;
			endcase
		end else begin
			o_rdata <= ZERO_WORD;
		end
	end
endmodule

// File: verification/xpt_dev_model.sv
// Behavioural crosspoint latch bank seen from its programming pins.
`timescale 1ns/10ps
module xpt_dev_model
	import xpt_ctl_pkg::*;
(
	input  wire logic              i_mclk,
	input  wire logic              i_reset_n,
	input  wire logic              i_cs_n,
	input  wire logic              i_write_n,
	input  wire logic              i_readback_enable_n,
	input  wire logic              i_update_n,
	input  wire logic [ADDR_W-1:0] i_out_sel,
	input  wire logic [DATA_W-1:0] i_data,
	input  wire logic              i_data_oe,
	output logic      [DATA_W-1:0] o_bus
);
	logic [DATA_W-1:0] rank1 [17];  // Preprogrammed words
	logic [DATA_W-1:0] rank2 [17];  // Active words
	logic [DATA_W-1:0] last = '0;   // Bus level a cycle back
	logic              we_q = 1'b1; // Strobes a cycle back
	logic              up_q = 1'b1;
	logic              drv;         // Device drives the bus
	assign drv = i_reset_n && !i_cs_n && i_write_n && !i_readback_enable_n && i_update_n;
	// Released bus toggles so stale data never reads as valid
	assign o_bus = i_data_oe ? i_data : (drv ? rank2[i_out_sel] : ~last);
	// Strobe edges seen one edge late, so no race with the controller
	// latch on rising strobe
	always @(posedge i_mclk) begin
		last <= o_bus;
		we_q <= i_write_n;
		up_q <= i_update_n;
		if (!i_reset_n) begin
			for (int k = 0; k < 17; k++) rank2[k][OE_BIT] <= 1'b0;
		end else if (!i_cs_n && i_write_n && !we_q) begin
			for (int k = 0; k < 17; k++) begin
				if (k == i_out_sel || i_out_sel == BCAST_ADR) begin
					if (up_q) rank1[k] <= o_bus;
					else rank2[k] <= o_bus;
				end
			end
		end else if (!i_cs_n && i_update_n && !up_q) begin
			for (int k = 0; k < 17; k++) rank2[k] <= rank1[k];
		end
	end
endmodule

// File: verification/xpt_ctl_sva.sv
// Port-level checks on the crosspoint programming controller.
`timescale 1ns/10ps
module xpt_ctl_sva
	import xpt_ctl_pkg::*;
(
	input wire logic              i_mclk,
	input wire logic              i_rst_n,
	input wire logic [3:0]        i_addr,
	input wire logic [31:0]       i_wdata,
	input wire logic              i_wr,
	input wire logic              i_rd,
	input wire logic [31:0]       o_rdata,
	input wire logic              o_reset_n,
	input wire logic              o_cs_n,
	input wire logic              o_write_n,
	input wire logic              o_readback_enable_n,
	input wire logic              o_update_n,
	input wire logic [ADDR_W-1:0] o_out_sel,
	input wire logic [DATA_W-1:0] i_data,
	input wire logic [DATA_W-1:0] o_data,
	input wire logic              o_data_oe
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	a_rst_release: assert property (!$past(i_rst_n) |-> !o_reset_n && o_cs_n && !o_data_oe)
		else $error("outputs not in reset state");
	a_strobe_cs: assert property (!(o_write_n && o_update_n && o_readback_enable_n) |-> !o_cs_n && $past(!o_cs_n))
		else $error("strobe without chip select margin");
	a_idle_free: assert property (o_cs_n |-> !o_data_oe && o_write_n && o_update_n && o_readback_enable_n)
		else $error("bus or strobe active while deselected");
	a_pulse_hold: assert property ($fell(o_write_n) |=> o_write_n && !o_cs_n && o_data_oe && $stable(o_data))
		else $error("write pulse or data hold wrong");
	a_update_one: assert property ($fell(o_update_n) |=> o_update_n ##1 o_cs_n)
		else $error("update pulse wrong");
	a_read_bus: assert property (!o_readback_enable_n |-> !o_data_oe && o_write_n && o_update_n && o_out_sel <= OUT_MAX)
		else $error("readback with bad bus or address");
	a_write_legal: assert property (!o_write_n |-> o_out_sel <= BCAST_ADR && o_data[5:0] <= IN_MAX)
		else $error("reserved address or input sent");
	a_upd_nodata: assert property (!o_update_n && o_write_n |-> !o_data_oe)
		else $error("update drives data");
	a_rdata_slot: assert property (!$past(i_rd) |-> o_rdata == ZERO_WORD)
		else $error("read data outside its slot");
	c_write: cover property ($rose(o_write_n) && o_update_n);
	c_transp: cover property ($rose(o_write_n) && $rose(o_update_n));
	c_read: cover property ($fell(o_readback_enable_n));
endmodule

// File: verification/tb_xpt_ctl.sv
// Self-checking bench for the crosspoint programming controller.
`timescale 1ns/10ps
module tb_xpt_ctl
	import xpt_ctl_pkg::*;
;
	logic              i_mclk  = 1'b0;          // Master clock
	logic              i_rst_n = 1'b0;          // Held low at start
	logic [3:0]        i_addr  = 4'h0;          // Register port
	logic [31:0]       i_wdata = 32'h0000_0000;
	logic              i_wr    = 1'b0;
	logic              i_rd    = 1'b0;
	logic [31:0]       o_rdata, q;
	logic              o_reset_n, o_cs_n, o_write_n, o_readback_enable_n, o_update_n, o_data_oe;
	logic [ADDR_W-1:0] o_out_sel;
	logic [DATA_W-1:0] o_data, i_data;          // Data bus level
	int                error_cnt = 0;
	int                n_tests   = 0;
	// Row: command, output read back, expected word
	typedef struct packed {op_t op; logic [4:0] a; logic [6:0] d; logic [4:0] ra; logic [6:0] e;} row_t;
	row_t rows [4] = '{'{OP_TRANSP, 5'h11, 7'h0A, 5'h03, 7'h0A}, '{OP_PREPROG, 5'h11, 7'h4B, 5'h00, 7'h0A},
		'{OP_PREPROG, 5'h00, 7'h40, 5'h00, 7'h0A}, '{OP_UPDATE, 5'h00, 7'h00, 5'h00, 7'h40}};
	// Controller under test, every pin named
	xpt_ctl u_xpt_ctl (
		.i_mclk              (i_mclk),
		.i_rst_n             (i_rst_n),
		.i_addr              (i_addr),
		.i_wdata             (i_wdata),
		.i_wr                (i_wr),
		.i_rd                (i_rd),
		.o_rdata             (o_rdata),
		.o_reset_n           (o_reset_n),
		.o_cs_n              (o_cs_n),
		.o_write_n           (o_write_n),
		.o_readback_enable_n (o_readback_enable_n),
		.o_update_n          (o_update_n),
		.o_out_sel           (o_out_sel),
		.i_data              (i_data),
		.o_data              (o_data),
		.o_data_oe           (o_data_oe)
	);
	// Latch bank model on the far side of the pins
	xpt_dev_model u_xpt_dev_model (.i_mclk, .i_reset_n(o_reset_n), .i_cs_n(o_cs_n), .i_write_n(o_write_n),
		.i_readback_enable_n(o_readback_enable_n), .i_update_n(o_update_n), .i_out_sel(o_out_sel),
		.i_data(o_data), .i_data_oe(o_data_oe), .o_bus(i_data));
	always #25 i_mclk = ~i_mclk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// Issue one command, then poll busy under a bound
	task automatic cmd(input op_t op, input logic [4:0] a, input logic [6:0] d);
		logic [31:0] s;
		wr(REG_CMD, {14'h0000, op, 3'h0, a, 1'h0, d});
		for (int k = 0; k < 20; k++) begin
			rd(REG_STATUS, s);
			if (s[ST_BUSY] === 1'b0) break;
		end
	endtask
	task automatic look(input logic [4:0] a, input logic [31:0] e);
		cmd(OP_READ, a, 7'h00);
		rd(REG_RDATA, q);
		chk("readback", e, q);
	endtask
	task automatic stop_test();
		$display("tests %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge i_mclk);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		rd(REG_STATUS, q);
		chk("status", 32'h0000_0004, q);
		wr(REG_RESET, 32'h0000_0001);
		$display("reset test done");
		foreach (rows[i]) begin
			cmd(rows[i].op, rows[i].a, rows[i].d);
			look(rows[i].ra, {25'h000_0000, rows[i].e});
		end
		$display("table test done");
		cmd(OP_READ, BCAST_ADR, 7'h00);
		rd(REG_STATUS, q);
		chk("status", 32'h0000_0002, q);
		wr(REG_STATUS, 32'h0000_0002);
		cmd(OP_PREPROG, 5'h00, 7'h61);
		cmd(OP_TRANSP, 5'h12, 7'h00);
		cmd(OP_UPDATE, 5'h00, 7'h00);
		look(5'h00, 32'h0000_0040);
		rd(REG_STATUS, q);
		chk("status", 32'h0000_0002, q);
		wr(REG_STATUS, 32'h0000_0002);
		$display("refusal test done");
		wr(REG_RESET, 32'h0000_0000);
		rd(REG_STATUS, q);
		chk("status", 32'h0000_0004, q);
		wr(REG_RESET, 32'h0000_0001);
		look(5'h10, 32'h0000_000B);
		rd(REG_CMD, q);
		chk("command reg", 32'h0001_1000, q);
		rd(REG_RESET, q);
		chk("reset reg", 32'h0000_0001, q);
		wr(4'h9, 32'hFFFF_FFFF);
		rd(REG_STATUS, q);
		chk("status", 32'h0000_0000, q);
		$display("device reset test done");
		stop_test();
	end
endmodule
bind xpt_ctl xpt_ctl_sva u_xpt_ctl_sva (
	.i_mclk              (i_mclk),
	.i_rst_n             (i_rst_n),
	.i_addr              (i_addr),
	.i_wdata             (i_wdata),
	.i_wr                (i_wr),
	.i_rd                (i_rd),
	.o_rdata             (o_rdata),
	.o_reset_n           (o_reset_n),
	.o_cs_n              (o_cs_n),
	.o_write_n           (o_write_n),
	.o_readback_enable_n (o_readback_enable_n),
	.o_update_n          (o_update_n),
	.o_out_sel           (o_out_sel),
	.i_data              (i_data),
	.o_data              (o_data),
	.o_data_oe           (o_data_oe)
);
